// [cbs_exec.sv]
`timescale 1ns/10ps
`default_nettype none
module cbs_exec (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             start,
  input  wire cbs_pkg::cbs_op_t op,
  input  wire logic [7:0]       rd_val,
  input  wire logic [7:0]       rr_val,
  input  wire logic [7:0]       imm_val,
  input  wire logic [2:0]       bit_sel,
  input  wire logic [2:0]       flag_sel,
  input  wire logic [6:0]       k_off,
  input  wire cbs_pkg::cbs_pc_t pc_in,
  input  wire logic             next_two_word,
  input  wire logic [7:0]       status_flags_register_in,
  input  wire logic [7:0]       io_rdata,
  output logic                  ready,
  output logic                  done,
  output cbs_pkg::cbs_pc_t      pc_out,
  output logic                  rd_we,
  output logic [7:0]            rd_wdata,
  output logic                  status_flags_register_we,
  output logic [7:0]            status_flags_register_out,
  output logic                  io_we,
  output logic [7:0]            io_wdata
);
  import cbs_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    cbs_state_t state;
    logic [1:0] remain;
    logic       done;
    cbs_pc_t    pc;
    logic       rd_we;
    logic [7:0] rd_wdata;
    logic       status_flags_register_we;
    logic [7:0] status_flags_register;
    logic       io_we;
    logic [7:0] io_wdata;
  } cbs_regs_t;

  cbs_regs_t  st_reg;
  cbs_regs_t  st_next;

  logic       take;
  cbs_pc_t    k_ext;
  logic [7:0] cmp_operand;
  logic       cmp_z;
  logic       cmp_n;
  logic       cmp_v;
  logic       cmp_c;
  logic       cmp_h;
  cbs_shift_t sh_kind;
  logic [7:0] sh_result;
  logic       sh_z;
  logic       sh_c;
  logic       sh_n;
  logic       sh_v;
  logic       is_branch;
  logic       br_flag;
  logic       br_want;
  logic       is_skip;
  logic       skip_hit;
  logic [1:0] cycles;
  cbs_pc_t    pc_target;

  // ****************************************
  // Datapath units
  // ****************************************
  // Compare operand: immediate or second register
  assign cmp_operand = (op == OP_COMPARE_IMMEDIATE) ? imm_val : rr_val;

  cbs_sub_flags u_sub (
    .minuend    (rd_val),
    .subtrahend (cmp_operand),
    .borrow_in  ((op == OP_COMPARE_REGS_CARRY) & status_flags_register_in[FLG_C]),
    .zero_chain (op == OP_COMPARE_REGS_CARRY),
    .zero_in    (status_flags_register_in[FLG_Z]),
    .flag_z     (cmp_z),
    .flag_n     (cmp_n),
    .flag_v     (cmp_v),
    .flag_c     (cmp_c),
    .flag_h     (cmp_h)
  );

  // Shift kind chosen from the operation
  always_comb begin
    unique case (op)
      OP_SHIFT_RIGHT_LOGICAL: sh_kind = SH_RIGHT_LOGICAL;
      OP_ROTATE_LEFT_CARRY:   sh_kind = SH_ROTATE_LEFT;
      OP_ROTATE_RIGHT_CARRY:  sh_kind = SH_ROTATE_RIGHT;
      OP_SHIFT_RIGHT_ARITH:   sh_kind = SH_RIGHT_ARITH;
      default:                sh_kind = SH_LEFT_LOGICAL;
    endcase
  end

  cbs_shift_unit u_shift (
    .kind     (sh_kind),
    .operand  (rd_val),
    .carry_in (status_flags_register_in[FLG_C]),
    .result   (sh_result),
    .flag_z   (sh_z),
    .flag_c   (sh_c),
    .flag_n   (sh_n),
    .flag_v   (sh_v)
  );

  // ****************************************
  // Branch and skip conditions
  // ****************************************
  // Signed word displacement of the branch
  assign k_ext = cbs_pc_t'(signed'(k_off));

  // Flag tested by each branch and the value that takes it
  always_comb begin
    is_branch = 1'b1;
    br_flag   = 1'b0;
    br_want   = 1'b1;
    unique case (op)
      OP_BRANCH_FLAG_SET:     br_flag = status_flags_register_in[flag_sel];
      OP_BRANCH_FLAG_CLEAR: begin
        br_flag = status_flags_register_in[flag_sel];
        br_want = 1'b0;
      end
      OP_BRANCH_EQUAL:        br_flag = status_flags_register_in[FLG_Z];
      OP_BRANCH_NOT_EQUAL: begin
        br_flag = status_flags_register_in[FLG_Z];
        br_want = 1'b0;
      end
      OP_BRANCH_CARRY_SET,
      OP_BRANCH_LOWER:        br_flag = status_flags_register_in[FLG_C];
      OP_BRANCH_CARRY_CLEAR,
      OP_BRANCH_SAME_OR_HIGH: begin
        br_flag = status_flags_register_in[FLG_C];
        br_want = 1'b0;
      end
      OP_BRANCH_MINUS:        br_flag = status_flags_register_in[FLG_N];
      OP_BRANCH_PLUS: begin
        br_flag = status_flags_register_in[FLG_N];
        br_want = 1'b0;
      end
      OP_BRANCH_GE_SIGNED: begin
        br_flag = status_flags_register_in[FLG_N] ^ status_flags_register_in[FLG_V];
        br_want = 1'b0;
      end
      OP_BRANCH_LESS_SIGNED:  br_flag = status_flags_register_in[FLG_N] ^ status_flags_register_in[FLG_V];
      OP_BRANCH_HALF_SET:     br_flag = status_flags_register_in[FLG_H];
      OP_BRANCH_HALF_CLEAR: begin
        br_flag = status_flags_register_in[FLG_H];
        br_want = 1'b0;
      end
      OP_BRANCH_TRANSFER_SET: br_flag = status_flags_register_in[FLG_T];
      OP_BRANCH_TRANSFER_CLR: begin
        br_flag = status_flags_register_in[FLG_T];
        br_want = 1'b0;
      end
      OP_BRANCH_OVERFLOW_SET: br_flag = status_flags_register_in[FLG_V];
      OP_BRANCH_OVERFLOW_CLR: begin
        br_flag = status_flags_register_in[FLG_V];
        br_want = 1'b0;
      end
      OP_BRANCH_IRQ_ENABLED:  br_flag = status_flags_register_in[FLG_I];
      OP_BRANCH_IRQ_DISABLED: begin
        br_flag = status_flags_register_in[FLG_I];
        br_want = 1'b0;
      end
      default:                is_branch = 1'b0;
    endcase
  end

  // Skip decision for register, I/O and compare skips
  always_comb begin
    is_skip  = 1'b1;
    skip_hit = 1'b0;
    unique case (op)
      OP_COMPARE_SKIP_EQUAL: skip_hit = (rd_val == rr_val);
      OP_SKIP_REG_BIT_CLEAR: skip_hit = ~rr_val[bit_sel];
      OP_SKIP_REG_BIT_SET:   skip_hit = rr_val[bit_sel];
      OP_SKIP_IO_BIT_CLEAR:  skip_hit = ~io_rdata[bit_sel];
      OP_SKIP_IO_BIT_SET:    skip_hit = io_rdata[bit_sel];
      default:               is_skip  = 1'b0;
    endcase
  end

  // Cycle count and next program counter
  always_comb begin
    cycles    = CYC_1;
    pc_target = cbs_pc_t'(pc_in + PC_STEP_1);
    if (is_branch && (br_flag == br_want)) begin
      cycles    = CYC_2;
      pc_target = cbs_pc_t'(pc_in + k_ext + PC_STEP_1);
    end else if (is_skip && skip_hit) begin
      cycles    = next_two_word ? CYC_3 : CYC_2;
      pc_target = cbs_pc_t'(pc_in + (next_two_word ? PC_STEP_3 : PC_STEP_2));
    end else if ((op == OP_SET_IO_BIT) || (op == OP_CLEAR_IO_BIT)) begin
      cycles = CYC_2;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  assign take = start && (st_reg.state == ST_IDLE);

  // Next state: latch results on take, release them with done
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    unique case (st_reg.state)
      ST_IDLE: begin
        if (take) begin
          st_next.pc       = pc_target;
          st_next.rd_we    = 1'b0;
          st_next.rd_wdata = rd_val;
          st_next.status_flags_register_we  = 1'b0;
          st_next.status_flags_register     = status_flags_register_in;
          st_next.io_we    = 1'b0;
          st_next.io_wdata = io_rdata;
          unique case (op)
            OP_COMPARE_REGS,
            OP_COMPARE_REGS_CARRY,
            OP_COMPARE_IMMEDIATE: begin
              st_next.status_flags_register_we       = 1'b1;
              st_next.status_flags_register[FLG_Z]   = cmp_z;
              st_next.status_flags_register[FLG_N]   = cmp_n;
              st_next.status_flags_register[FLG_V]   = cmp_v;
              st_next.status_flags_register[FLG_C]   = cmp_c;
              st_next.status_flags_register[FLG_H]   = cmp_h;
            end
            OP_SHIFT_LEFT_LOGICAL,
            OP_SHIFT_RIGHT_LOGICAL,
            OP_ROTATE_LEFT_CARRY,
            OP_ROTATE_RIGHT_CARRY,
            OP_SHIFT_RIGHT_ARITH: begin
              st_next.rd_we       = 1'b1;
              st_next.rd_wdata    = sh_result;
              st_next.status_flags_register_we     = 1'b1;
              st_next.status_flags_register[FLG_Z] = sh_z;
              st_next.status_flags_register[FLG_C] = sh_c;
              st_next.status_flags_register[FLG_N] = sh_n;
              st_next.status_flags_register[FLG_V] = sh_v;
            end
            OP_SET_IO_BIT: begin
              st_next.io_we    = 1'b1;
              st_next.io_wdata = io_rdata | (BIT0_MASK << bit_sel);
            end
            OP_CLEAR_IO_BIT: begin
              st_next.io_we    = 1'b1;
              st_next.io_wdata = io_rdata & ~(BIT0_MASK << bit_sel);
            end
            default: ;
          endcase
          if (cycles == CYC_1) begin
            st_next.done = 1'b1;
          end else begin
            st_next.state  = ST_WAIT;
            st_next.remain = 2'(cycles - CYC_1);
          end
        end
      end
      ST_WAIT: begin
        if (st_reg.remain == CYC_1) begin
          st_next.done  = 1'b1;
          st_next.state = ST_IDLE;
        end else begin
          st_next.remain = 2'(st_reg.remain - CYC_1);
        end
      end
    endcase
  end

  // State register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs; write strobes only pulse with done
  assign ready    = (st_reg.state == ST_IDLE);
  assign done     = st_reg.done;
  assign pc_out   = st_reg.pc;
  assign rd_we    = st_reg.rd_we & st_reg.done;
  assign rd_wdata = st_reg.rd_wdata;
  assign status_flags_register_we  = st_reg.status_flags_register_we & st_reg.done;
  assign status_flags_register_out = st_reg.status_flags_register;
  assign io_we    = st_reg.io_we & st_reg.done;
  assign io_wdata = st_reg.io_wdata;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence s_done_after_two;
    !done ##1 done;
  endsequence

  sequence s_done_after_three;
    !done ##1 !done ##1 done;
  endsequence

  AST_EQUAL_SKIP_ONE_WORD: assert property (
    take && op == OP_COMPARE_SKIP_EQUAL && rd_val == rr_val && !next_two_word
    |=> s_done_after_two ##0 (pc_out == cbs_pc_t'($past(pc_in, 2) + PC_STEP_2) && !status_flags_register_we)
  ) else $error("equal skip over one word wrong");

  AST_SKIP_TWO_WORD: assert property (
    take && op == OP_SKIP_REG_BIT_SET && rr_val[bit_sel] && next_two_word
    |=> s_done_after_three ##0 (pc_out == cbs_pc_t'($past(pc_in, 3) + PC_STEP_3))
  ) else $error("skip over two words wrong");

  AST_COMPARE_FLAGS: assert property (
    take && op == OP_COMPARE_REGS
    |=> done && status_flags_register_we && status_flags_register_out[FLG_Z] == ($past(rd_val) == $past(rr_val))
        && status_flags_register_out[FLG_C] == ($past(rd_val) < $past(rr_val))
  ) else $error("compare flags wrong");

  AST_IO_SKIP_MISS: assert property (
    take && op == OP_SKIP_IO_BIT_SET && !io_rdata[bit_sel]
    |=> done && !status_flags_register_we && pc_out == cbs_pc_t'($past(pc_in) + PC_STEP_1)
  ) else $error("io skip not taken wrong");

  AST_FLAG_BRANCH_TAKEN: assert property (
    take && op == OP_BRANCH_FLAG_SET && status_flags_register_in[flag_sel]
    |=> s_done_after_two ##0 (pc_out == cbs_pc_t'($past(pc_in, 2) + $past(k_ext, 2) + PC_STEP_1))
  ) else $error("flag branch target wrong");

  AST_BRANCH_NOT_TAKEN: assert property (
    take && op == OP_BRANCH_EQUAL && !status_flags_register_in[FLG_Z]
    |=> done && ready && pc_out == cbs_pc_t'($past(pc_in) + PC_STEP_1)
  ) else $error("branch not taken wrong");

  AST_SIGNED_LESS: assert property (
    take && op == OP_BRANCH_LESS_SIGNED && (status_flags_register_in[FLG_N] ^ status_flags_register_in[FLG_V])
    |=> !ready ##1 (done && !status_flags_register_we)
  ) else $error("signed branch timing wrong");

  AST_IO_SET_BIT: assert property (
    take && op == OP_SET_IO_BIT
    |=> s_done_after_two ##0 (io_we
        && io_wdata == ($past(io_rdata, 2) | (BIT0_MASK << $past(bit_sel, 2))))
  ) else $error("io bit set wrong");

  AST_SHIFT_LEFT: assert property (
    take && op == OP_SHIFT_LEFT_LOGICAL
    |=> done && rd_we && rd_wdata == 8'($past(rd_val) << 1)
        && status_flags_register_out[FLG_C] == $past(rd_val[7])
  ) else $error("left shift wrong");

  AST_ROTATE_LEFT: assert property (
    take && op == OP_ROTATE_LEFT_CARRY
    |=> rd_we && rd_wdata[0] == $past(status_flags_register_in[FLG_C]) && status_flags_register_out[FLG_C] == $past(rd_val[7])
  ) else $error("rotate left wrong");

  AST_ARITH_SHIFT: assert property (
    take && op == OP_SHIFT_RIGHT_ARITH
    |=> rd_we && rd_wdata[7] == $past(rd_val[7]) && rd_wdata[6:0] == 7'($past(rd_val) >> 1)
        && status_flags_register_out[FLG_C] == $past(rd_val[0])
  ) else $error("arithmetic shift wrong");

endmodule // cbs_exec
`default_nettype wire

// [cbs_pkg.sv]
package cbs_pkg;

  // ****************************************
  // Widths and field positions
  // ****************************************
  localparam int unsigned PC_W = 16;
  typedef logic [PC_W-1:0] cbs_pc_t;

  // Status flag bit positions
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_H = 3'h5;
  localparam logic [2:0] FLG_T = 3'h6;
  localparam logic [2:0] FLG_I = 3'h7;

  // Cycle counts and program counter steps
  localparam logic [1:0] CYC_1     = 2'h1;
  localparam logic [1:0] CYC_2     = 2'h2;
  localparam logic [1:0] CYC_3     = 2'h3;
  localparam cbs_pc_t    PC_STEP_1 = 16'h0001;
  localparam cbs_pc_t    PC_STEP_2 = 16'h0002;
  localparam cbs_pc_t    PC_STEP_3 = 16'h0003;
  localparam logic [7:0] BIT0_MASK = 8'h01;

  // ****************************************
  // Operations
  // ****************************************
  typedef enum logic [5:0] {
    OP_NOP                  = 6'b000000,
    OP_COMPARE_SKIP_EQUAL   = 6'b000001,
    OP_COMPARE_REGS         = 6'b000010,
    OP_COMPARE_REGS_CARRY   = 6'b000011,
    OP_COMPARE_IMMEDIATE    = 6'b000100,
    OP_SKIP_REG_BIT_CLEAR   = 6'b000101,
    OP_SKIP_REG_BIT_SET     = 6'b000110,
    OP_SKIP_IO_BIT_CLEAR    = 6'b000111,
    OP_SKIP_IO_BIT_SET      = 6'b001000,
    OP_BRANCH_FLAG_SET      = 6'b001001,
    OP_BRANCH_FLAG_CLEAR    = 6'b001010,
    OP_BRANCH_EQUAL         = 6'b001011,
    OP_BRANCH_NOT_EQUAL     = 6'b001100,
    OP_BRANCH_CARRY_SET     = 6'b001101,
    OP_BRANCH_CARRY_CLEAR   = 6'b001110,
    OP_BRANCH_SAME_OR_HIGH  = 6'b001111,
    OP_BRANCH_LOWER         = 6'b010000,
    OP_BRANCH_MINUS         = 6'b010001,
    OP_BRANCH_PLUS          = 6'b010010,
    OP_BRANCH_GE_SIGNED     = 6'b010011,
    OP_BRANCH_LESS_SIGNED   = 6'b010100,
    OP_BRANCH_HALF_SET      = 6'b010101,
    OP_BRANCH_HALF_CLEAR    = 6'b010110,
    OP_BRANCH_TRANSFER_SET  = 6'b010111,
    OP_BRANCH_TRANSFER_CLR  = 6'b011000,
    OP_BRANCH_OVERFLOW_SET  = 6'b011001,
    OP_BRANCH_OVERFLOW_CLR  = 6'b011010,
    OP_BRANCH_IRQ_ENABLED   = 6'b011011,
    OP_BRANCH_IRQ_DISABLED  = 6'b011100,
    OP_SET_IO_BIT           = 6'b011101,
    OP_CLEAR_IO_BIT         = 6'b011110,
    OP_SHIFT_LEFT_LOGICAL   = 6'b011111,
    OP_SHIFT_RIGHT_LOGICAL  = 6'b100000,
    OP_ROTATE_LEFT_CARRY    = 6'b100001,
    OP_ROTATE_RIGHT_CARRY   = 6'b100010,
    OP_SHIFT_RIGHT_ARITH    = 6'b100011
  } cbs_op_t;

  typedef enum logic [2:0] {
    SH_LEFT_LOGICAL  = 3'b000,
    SH_RIGHT_LOGICAL = 3'b001,
    SH_ROTATE_LEFT   = 3'b010,
    SH_ROTATE_RIGHT  = 3'b011,
    SH_RIGHT_ARITH   = 3'b100
  } cbs_shift_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } cbs_state_t;

endpackage

// [cbs_sub_flags.sv]
`timescale 1ns/10ps
`default_nettype none
module cbs_sub_flags (
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  input  wire logic       borrow_in,
  input  wire logic       zero_chain,
  input  wire logic       zero_in,
  output logic            flag_z,
  output logic            flag_n,
  output logic            flag_v,
  output logic            flag_c,
  output logic            flag_h
);
  import cbs_pkg::*;

  logic [7:0] diff;

  // Difference with borrow and its flags; result itself is discarded
  always_comb begin
    diff   = 8'(minuend - subtrahend - {7'h00, borrow_in});
    flag_n = diff[7];
    flag_h = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & diff[3]) | (diff[3] & ~minuend[3]);
    flag_c = (~minuend[7] & subtrahend[7]) | (subtrahend[7] & diff[7]) | (diff[7] & ~minuend[7]);
    flag_v = (minuend[7] & ~subtrahend[7] & ~diff[7]) | (~minuend[7] & subtrahend[7] & diff[7]);
    // Chained compare keeps zero only if it was already zero
    flag_z = (diff == 8'h00) & (~zero_chain | zero_in);
  end

endmodule // cbs_sub_flags
`default_nettype wire

// [cbs_shift_unit.sv]
`timescale 1ns/10ps
`default_nettype none
module cbs_shift_unit (
  input  wire cbs_pkg::cbs_shift_t kind,
  input  wire logic [7:0]          operand,
  input  wire logic                carry_in,
  output logic [7:0]               result,
  output logic                     flag_z,
  output logic                     flag_c,
  output logic                     flag_n,
  output logic                     flag_v
);
  import cbs_pkg::*;

  // Shift or rotate by one place and derive the flags
  always_comb begin
    unique case (kind)
      SH_LEFT_LOGICAL:  {flag_c, result} = {operand, 1'b0};
      SH_RIGHT_LOGICAL: {result, flag_c} = {1'b0, operand};
      SH_ROTATE_LEFT:   {flag_c, result} = {operand, carry_in};
      SH_ROTATE_RIGHT:  {result, flag_c} = {carry_in, operand};
      SH_RIGHT_ARITH:   {result, flag_c} = {operand[7], operand}; // Sign bit kept
      default:          {flag_c, result} = {1'b0, operand};
    endcase
    flag_z = (result == 8'h00);
    flag_n = result[7];
    flag_v = result[7] ^ flag_c;
  end

endmodule // cbs_shift_unit
`default_nettype wire

// [cbs_exec_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module cbs_exec_bench;
  import cbs_pkg::*;
  localparam cbs_pc_t    PCB = 16'h0020;
  localparam logic [7:0] SKB = 8'h5a;
  localparam int         TMO = 5000;
  logic       clk_sys, nrst, start, next_two_word, ready, done, rd_we, status_flags_register_we, io_we;
  cbs_op_t    op, bo;
  logic [7:0] rd_val, rr_val, imm_val, status_flags_register_in, io_rdata, rd_wdata, status_flags_register_out, io_wdata, bs, e;
  logic [2:0] bit_sel, flag_sel;
  logic [6:0] k_off, k;
  cbs_pc_t    pc_in, pc_out;
  logic       t, two;
  int         errors, n_checks, cyc, ncyc, n;
  cbs_op_t    cop[6] = '{OP_COMPARE_REGS, OP_COMPARE_REGS, OP_COMPARE_REGS,
                         OP_COMPARE_REGS_CARRY, OP_COMPARE_REGS_CARRY, OP_COMPARE_IMMEDIATE};
  logic [7:0] ca[6]  = '{8'h05, 8'h00, 8'h80, 8'h05, 8'h05, 8'h10};
  logic [7:0] cb[6]  = '{8'h05, 8'h01, 8'h01, 8'h04, 8'h04, 8'h01};
  logic [7:0] cs[6]  = '{8'h00, 8'hd0, 8'h00, 8'h03, 8'h01, 8'hff};
  cbs_op_t    sop[6] = '{OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
                         OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH, OP_SHIFT_LEFT_LOGICAL};
  logic [7:0] sa[6]  = '{8'h81, 8'h81, 8'h81, 8'h81, 8'h81, 8'h80};
  logic [7:0] ss[6]  = '{8'h60, 8'h60, 8'h61, 8'h61, 8'h60, 8'h60};
  logic [7:0] sr[6]  = '{8'h02, 8'h40, 8'h03, 8'hc0, 8'hc0, 8'h00};
  logic [7:0] se[6]  = '{8'h69, 8'h69, 8'h69, 8'h65, 8'h65, 8'h6b};
  cbs_op_t    sk[4]  = '{OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
                         OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET};

  cbs_exec dut (
    .clk_sys(clk_sys), .nrst(nrst), .start(start), .op(op), .rd_val(rd_val),
    .rr_val(rr_val), .imm_val(imm_val), .bit_sel(bit_sel), .flag_sel(flag_sel),
    .k_off(k_off), .pc_in(pc_in), .next_two_word(next_two_word), .status_flags_register_in(status_flags_register_in),
    .io_rdata(io_rdata), .ready(ready), .done(done), .pc_out(pc_out), .rd_we(rd_we),
    .rd_wdata(rd_wdata), .status_flags_register_we(status_flags_register_we), .status_flags_register_out(status_flags_register_out), .io_we(io_we),
    .io_wdata(io_wdata)
  );

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == TMO) begin
      errors++;
      give_verdict();
    end
  end

  // ****************************************
  // Compare, drive and verdict tasks
  // ****************************************
  task automatic chk8(input string nm, input logic [7:0] ex, input logic [7:0] g);
    n_checks++;
    if (g !== ex) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task automatic chk16(input string nm, input cbs_pc_t ex, input cbs_pc_t g);
    n_checks++;
    if (g !== ex) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Operand b goes only to the source the op reads; the others see its inverse
  task automatic exec(input cbs_op_t o, input logic [7:0] a, b, s, input logic [2:0] sel,
                      input logic [6:0] kk, input logic tw);
    logic io, im;
    io = o inside {OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET, OP_SET_IO_BIT, OP_CLEAR_IO_BIT};
    im = (o == OP_COMPARE_IMMEDIATE);
    @(posedge clk_sys);
    start <= 1'b1;
    op <= o;
    rd_val <= a;
    rr_val <= (io || im) ? ~b : b;
    imm_val <= im ? b : ~b;
    io_rdata <= io ? b : ~b;
    status_flags_register_in <= s;
    bit_sel <= sel;
    flag_sel <= sel;
    k_off <= kk;
    next_two_word <= tw;
    pc_in <= PCB;
    @(posedge clk_sys);
    start <= 1'b0;
    ncyc = 1;
    #1;
    // A one-cycle op shows done just after the take edge, so look before waiting
    while (done !== 1'b1 && ncyc < 4) begin
      @(posedge clk_sys);
      #1;
      ncyc++;
    end
  endtask

  // Strobes packed as rd_we, status_flags_register_we, io_we
  task automatic post(input cbs_pc_t epc, input logic [1:0] ec, input logic [2:0] we);
    chk16("pc_out", epc, pc_out);
    chk8("cycles", {6'h0, ec}, 8'(ncyc));
    chk8("strobes", {5'h0, we}, {5'h0, rd_we, status_flags_register_we, io_we});
  endtask

  // Flags of a compare; only Z, N, V, C, H move
  function automatic logic [7:0] exp_cmp(input logic [7:0] a, b, s, input logic cc);
    logic [7:0] r, f;
    r = a - b - {7'h0, cc & s[0]};
    f = s & 8'hd0;
    f[0] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    f[5] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
    f[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    f[2] = r[7];
    f[1] = (r == 8'h00) && (!cc || s[1]);
    return f;
  endfunction

  // Branch condition per op
  function automatic logic taken(input cbs_op_t o, input logic [7:0] s, input logic [2:0] sel);
    case (o)
      OP_BRANCH_FLAG_SET:                           return s[sel];
      OP_BRANCH_FLAG_CLEAR:                         return !s[sel];
      OP_BRANCH_EQUAL:                              return s[1];
      OP_BRANCH_NOT_EQUAL:                          return !s[1];
      OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER:         return s[0];
      OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_OR_HIGH: return !s[0];
      OP_BRANCH_MINUS:                              return s[2];
      OP_BRANCH_PLUS:                               return !s[2];
      OP_BRANCH_GE_SIGNED:                          return !(s[2] ^ s[3]);
      OP_BRANCH_LESS_SIGNED:                        return s[2] ^ s[3];
      OP_BRANCH_HALF_SET:                           return s[5];
      OP_BRANCH_HALF_CLEAR:                         return !s[5];
      OP_BRANCH_TRANSFER_SET:                       return s[6];
      OP_BRANCH_TRANSFER_CLR:                       return !s[6];
      OP_BRANCH_OVERFLOW_SET:                       return s[3];
      OP_BRANCH_OVERFLOW_CLR:                       return !s[3];
      OP_BRANCH_IRQ_ENABLED:                        return s[7];
      default:                                      return !s[7];
    endcase
  endfunction

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    errors = 0;
    n_checks = 0;
    cyc = 0;
    {nrst, start, next_two_word} = 3'h0;
    op = OP_NOP;
    {rd_val, rr_val, imm_val, status_flags_register_in, io_rdata} = 40'h0;
    {bit_sel, flag_sel, k_off} = 13'h0;
    pc_in = 16'h0000;
    repeat (20) @(posedge clk_sys);
    #1;
    chk8("ready_done", 8'h02, {6'h0, ready, done});
    @(posedge clk_sys);
    nrst <= 1'b1;
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      exec(cop[i], ca[i], cb[i], cs[i], 3'h0, 7'h0, 1'b0);
      post(PCB + 16'h1, 2'h1, 3'h2);
      chk8("status_flags_register_out", exp_cmp(ca[i], cb[i], cs[i], i == 3 || i == 4), status_flags_register_out);
    end
    $display("test compares done");
    for (int j = 0; j < 3; j++) begin
      exec(OP_COMPARE_SKIP_EQUAL, 8'h3c, (j == 2) ? 8'h3d : 8'h3c, 8'hff, 3'h0, 7'h0, j[0]);
      post(PCB + 16'((j == 2) ? 1 : 2 + j), 2'((j == 2) ? 1 : 2 + j), 3'h0);
    end
    for (int i = 0; i < 32; i++) begin
      two = i[2] ^ i[0];
      t = (SKB[i % 8] == ((i / 8) % 2));
      n = t ? 2 + int'(two) : 1;
      exec(sk[i / 8], 8'h00, SKB, 8'h00, 3'(i), 7'h0, two);
      post(PCB + 16'(n), 2'(n), 3'h0);
    end
    $display("test skips done");
    for (int i = 0; i < 16; i++) begin
      e = (i < 8) ? (SKB | (8'h01 << (i % 8))) : (SKB & ~(8'h01 << (i % 8)));
      exec((i < 8) ? OP_SET_IO_BIT : OP_CLEAR_IO_BIT, 8'h00, SKB, 8'hff, 3'(i), 7'h0, 1'b0);
      post(PCB + 16'h1, 2'h2, 3'h1);
      chk8("io_wdata", e, io_wdata);
    end
    $display("test io bits done");
    for (int i = 0; i < 6; i++) begin
      exec(sop[i], sa[i], 8'h00, ss[i], 3'h0, 7'h0, 1'b0);
      post(PCB + 16'h1, 2'h1, 3'h6);
      chk8("rd_wdata", sr[i], rd_wdata);
      chk8("status_flags_register_out", se[i], status_flags_register_out);
    end
    $display("test shifts done");
    for (int i = 0; i < 60; i++) begin
      bo = cbs_op_t'(6'(9 + i / 3));
      bs = (i % 3 == 0) ? 8'h00 : ((i % 3 == 1) ? 8'hff : 8'h04);
      k = 7'(i * 37);
      t = taken(bo, bs, 3'(i));
      exec(bo, 8'h00, 8'h00, bs, 3'(i), k, 1'b0);
      post(t ? PCB + {{9{k[6]}}, k} + 16'h1 : PCB + 16'h1, t ? 2'h2 : 2'h1, 3'h0);
    end
    $display("test branches done");
    give_verdict();
  end
endmodule // cbs_exec_bench
`default_nettype wire
